// *** include/lbc_regs.vh ***
`ifndef LBC_REGS_VH
`define LBC_REGS_VH
// Counter and code layout
`define LBC_DAC_W 5
`define LBC_DAC_MID 5'h10
`define LBC_DAC_FULL 5'h1f
`define LBC_DAC_ZERO 5'h00
// Target address
`define LBC_ADDR 7'h2c
// Configuration byte fields
`define LBC_SEL_BIT 7
`define LBC_RUN_BIT 6
`define LBC_PANEL_BIT 5
// Status byte fields
`define LBC_STAT_PG_BIT 7
// Power-up configuration values {run, panel}
`define LBC_OPER_RST 2'h3
`define LBC_SUSP_RST 2'h0
`endif

// *** verilog/lbc_sync.v ***
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of pin inputs
module lbc_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Data
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    // Capture then settle
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_q <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // lbc_sync

// *** verilog/lbc_ctrl.v ***
`timescale 1ns/1ps
`include "lbc_regs.vh"

// Operation
// - Counter loads 10000 at reset.
// - Raise edge decrements counter, positive polarity.
// - Lower edge increments counter, positive polarity.
// - Both pins high forces half-scale.
// - Counter saturates at both ends.
// - Negative polarity swaps counting direction.
// - Shutdown zeroes output, floats panel, freezes.
// - Undervoltage lockout reloads midscale.
// - Midscale is 15 up, 16 down.
// - Power-good low floats panel switch.
// - Respond only to address 0101100.
// - Bit 7 selects config; bits split.
// - Bit 6 run, bit 5 panel.
// - Suspend pin picks active config.
// - Every written byte updates DAC code.
// - DAC code kept through shutdown, suspend.
// - Read-byte returns status byte.
// - Serial interface works while shut down.
// - Panel output gated by panel bit.
// - Panel pulls low only when power-good, panel bit and run all true.
// - Status: power-good while running, reserved, DAC code.
// - Operating config resets to run, panel enabled.
module lbc_ctrl #(
    parameter SERIAL_MODE = 1
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Supply and analog status
    input wire undervoltage_lockout,
    input wire power_good_input,
    input wire polarity_select,
    // Pin-controlled variant
    input wire raise_magnitude_pin,
    input wire lower_magnitude_pin,
    input wire shutdown_n_pin,
    // Serial variant
    input wire suspend_n_pin,
    input wire scl_in,
    input wire sda_in,
    output reg sda_oe_n,
    // Outputs
    output reg [4:0] dac_out,
    output reg panel_switch_oe_n,
    output reg running
);
    // Pin synchroniser outputs
    wire [7:0] pins_s;
    lbc_sync #(.W(8)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({undervoltage_lockout, power_good_input, polarity_select, raise_magnitude_pin,
                   lower_magnitude_pin, shutdown_n_pin, suspend_n_pin, scl_in}),
        .sync_out(pins_s)
    );
    wire lockout_s = pins_s[7];
    wire pg_s = pins_s[6];
    wire polarity_s = pins_s[5];
    wire up_s = pins_s[4];
    wire lwr_s = pins_s[3];
    wire shut_n_s = pins_s[2];
    wire susp_n_s = pins_s[1];
    wire scl_s = pins_s[0];

    // SDA is synchronised separately
    wire sda_s;
    lbc_sync #(.W(1)) u_sync_sda (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(sda_in),
        .sync_out(sda_s)
    );

    // Saturating step helper
    function [4:0] step;
        input [4:0] v;
        input inc;
        begin
            if (inc)
                step = (v == `LBC_DAC_FULL) ? v : v + 5'h01;
            else
                step = (v == `LBC_DAC_ZERO) ? v : v - 5'h01;
        end
    endfunction

    // Registers
    reg [4:0] dac_q;
    reg [1:0] oper_cfg_q;
    reg [1:0] susp_cfg_q;
    reg up_q;
    reg lwr_q;
    reg scl_q;
    reg sda_q;

    // Active configuration
    wire [1:0] act_cfg = susp_n_s ? oper_cfg_q : susp_cfg_q;
    wire run_now = SERIAL_MODE ? act_cfg[1] : shut_n_s;
    wire panel_en = SERIAL_MODE ? act_cfg[0] : 1'b1;

    // Pin edge detection on synchronised levels
    wire up_rise = up_s & ~up_q;
    wire lwr_rise = lwr_s & ~lwr_q;

    // Serial target state
    localparam S_IDLE = 3'h0;
    localparam S_ADDR = 3'h1;
    localparam S_AACK = 3'h2;
    localparam S_WDAT = 3'h3;
    localparam S_DACK = 3'h4;
    localparam S_RDAT = 3'h5;
    localparam S_RACK = 3'h6;
    localparam S_SKIP = 3'h7;
    reg [2:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg rd_q;
    reg wr_done;

    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_c = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c = scl_s & scl_q & ~sda_q & sda_s;
    wire [7:0] status_b = {pg_s & run_now, 2'b00, dac_q};

    // Bus state machine, runs regardless of shutdown
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= S_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            sda_oe_n <= 1'b1;
            wr_done <= 1'b0;
            scl_q <= 1'b0;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            wr_done <= 1'b0;
            if (SERIAL_MODE == 0)
            begin
                st_q <= S_IDLE;
                sda_oe_n <= 1'b1;
            end
            else if (start_c)
            begin
                st_q <= S_ADDR;
                bit_q <= 4'h0;
                sda_oe_n <= 1'b1;
            end
            else if (stop_c)
            begin
                st_q <= S_IDLE;
                sda_oe_n <= 1'b1;
            end
            else
            begin
                case (st_q)
                    S_IDLE:
                    begin
                        sda_oe_n <= 1'b1;
                    end
                    S_ADDR, S_WDAT:
                    begin
                        if (scl_rise)
                        begin
                            sh_q <= {sh_q[6:0], sda_s};
                            bit_q <= bit_q + 4'h1;
                        end
                        else if (scl_fall && bit_q == 4'h8)
                        begin
                            bit_q <= 4'h0;
                            if (st_q == S_WDAT)
                            begin
                                sda_oe_n <= 1'b0;
                                wr_done <= 1'b1;
                                st_q <= S_DACK;
                            end
                            else if (sh_q[7:1] == `LBC_ADDR)
                            begin
                                rd_q <= sh_q[0];
                                sda_oe_n <= 1'b0;
                                st_q <= S_AACK;
                            end
                            else
                                st_q <= S_SKIP;
                        end
                    end
                    S_AACK:
                    begin
                        if (scl_fall)
                        begin
                            if (rd_q)
                            begin
                                sh_q <= {status_b[6:0], 1'b0};
                                sda_oe_n <= status_b[7];
                                bit_q <= 4'h1;
                                st_q <= S_RDAT;
                            end
                            else
                            begin
                                sda_oe_n <= 1'b1;
                                st_q <= S_WDAT;
                            end
                        end
                    end
                    S_DACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe_n <= 1'b1;
                            st_q <= S_WDAT;
                        end
                    end
                    S_RDAT:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_q == 4'h8)
                            begin
                                sda_oe_n <= 1'b1;
                                st_q <= S_RACK;
                            end
                            else
                            begin
                                sda_oe_n <= sh_q[7];
                                sh_q <= {sh_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    end
                    S_RACK:
                    begin
                        if (scl_fall)
                            st_q <= S_SKIP;
                    end
                    S_SKIP:
                    begin
                        sda_oe_n <= 1'b1;
                    end
                    default:
                    begin
                        st_q <= S_IDLE;
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Configuration registers and DAC counter
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dac_q <= `LBC_DAC_MID;
            oper_cfg_q <= `LBC_OPER_RST;
            susp_cfg_q <= `LBC_SUSP_RST;
            up_q <= 1'b0;
            lwr_q <= 1'b0;
        end
        else
        begin
            up_q <= up_s;
            lwr_q <= lwr_s;
            if (lockout_s)
            begin
                dac_q <= `LBC_DAC_MID;
                oper_cfg_q <= `LBC_OPER_RST;
                susp_cfg_q <= `LBC_SUSP_RST;
            end
            else if (SERIAL_MODE != 0)
            begin
                if (wr_done)
                begin
                    dac_q <= sh_q[4:0];
                    if (sh_q[`LBC_SEL_BIT])
                        oper_cfg_q <= {sh_q[`LBC_RUN_BIT], sh_q[`LBC_PANEL_BIT]};
                    else
                        susp_cfg_q <= {sh_q[`LBC_RUN_BIT], sh_q[`LBC_PANEL_BIT]};
                end
            end
            else if (shut_n_s)
            begin
                if (up_s && lwr_s)
                    dac_q <= `LBC_DAC_MID;
                else if (up_rise)
                    dac_q <= step(dac_q, ~polarity_s);
                else if (lwr_rise)
                    dac_q <= step(dac_q, polarity_s);
            end
        end
    end

    // Registered outputs
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dac_out <= `LBC_DAC_ZERO;
            panel_switch_oe_n <= 1'b1;
            running <= 1'b0;
        end
        else
        begin
            running <= run_now;
            dac_out <= run_now ? dac_q : `LBC_DAC_ZERO;
            panel_switch_oe_n <= ~(pg_s & panel_en & run_now);
        end
    end
endmodule // lbc_ctrl

// *** verification/lbc_props.sv ***
`timescale 1ns/1ps
// Port checks for the bias counter control
module lbc_props #(
    parameter SERIAL_MODE = 1
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Inputs
    input wire undervoltage_lockout,
    input wire power_good_input,
    input wire polarity_select,
    input wire raise_magnitude_pin,
    input wire lower_magnitude_pin,
    input wire shutdown_n_pin,
    input wire scl_in,
    // Outputs
    input wire sda_oe_n,
    input wire [4:0] dac_out,
    input wire panel_switch_oe_n,
    input wire running
);
    // Pins that step the count up or down
    wire pin = SERIAL_MODE == 0;
    wire up_pin = polarity_select ? lower_magnitude_pin : raise_magnitude_pin;
    wire down_pin = polarity_select ? raise_magnitude_pin : lower_magnitude_pin;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_up;
        pin && $past(dac_out) != 5'h00 && dac_out != 5'h10 && dac_out > $past(dac_out) |->
            dac_out == $past(dac_out) + 5'h01 && ($past(up_pin, 4) || $past(up_pin, 5) || $past(up_pin, 6));
    endproperty
    a_up: assert property (p_up) else $error("bad up step");
    property p_down;
        pin && dac_out != 5'h00 && dac_out != 5'h10 && dac_out < $past(dac_out) |->
            dac_out == $past(dac_out) - 5'h01 && ($past(down_pin, 4) || $past(down_pin, 5) || $past(down_pin, 6));
    endproperty
    a_down: assert property (p_down) else $error("bad down step");
    property p_both_mid;
        (pin && shutdown_n_pin && raise_magnitude_pin && lower_magnitude_pin)[*6] |-> dac_out == 5'h10;
    endproperty
    a_both_mid: assert property (p_both_mid) else $error("both pins high not midscale");
    property p_halt_zero;
        (pin && !shutdown_n_pin)[*4] |-> dac_out == 5'h00 && panel_switch_oe_n;
    endproperty
    a_halt_zero: assert property (p_halt_zero) else $error("shutdown output not zero");
    property p_off_zero;
        !running && !$past(running) |-> dac_out == 5'h00;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("stopped with nonzero code");
    property p_pg_float;
        (!power_good_input)[*4] |-> panel_switch_oe_n;
    endproperty
    a_pg_float: assert property (p_pg_float) else $error("panel pulled without power good");
    property p_lockout_mid;
        (undervoltage_lockout[*6]) ##0 running |-> dac_out == 5'h10;
    endproperty
    a_lockout_mid: assert property (p_lockout_mid) else $error("lockout not midscale");
    property p_sda_edge;
        $changed(sda_oe_n) |-> !scl_in && !pin;
    endproperty
    a_sda_edge: assert property (p_sda_edge) else $error("data line moved badly");
    c_both: cover property ((raise_magnitude_pin && lower_magnitude_pin)[*6]);
    c_ack: cover property ($fell(sda_oe_n));
    c_lockout: cover property (undervoltage_lockout[*6]);
endmodule // lbc_props

bind lbc_ctrl lbc_props #(.SERIAL_MODE(SERIAL_MODE)) u_props (.clk(clk), .sys_rst(sys_rst),
    .undervoltage_lockout(undervoltage_lockout), .power_good_input(power_good_input),
    .polarity_select(polarity_select), .raise_magnitude_pin(raise_magnitude_pin),
    .lower_magnitude_pin(lower_magnitude_pin), .shutdown_n_pin(shutdown_n_pin), .scl_in(scl_in),
    .sda_oe_n(sda_oe_n), .dac_out(dac_out), .panel_switch_oe_n(panel_switch_oe_n), .running(running));

// *** verification/lbc_host.sv ***
`timescale 1ns/1ps
// Bus host model; its clock idles high between frames
module lbc_host (
    // Bus lines
    input wire sda,
    output reg scl,
    output reg sda_oe_n
);
    reg [1:0] ack;
    reg [7:0] rd;
    // Bus released at start
    initial
    begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
    end
    // One bit slot; data moves only while the clock is low
    task bit_io(input logic b, output logic r);
    begin
        #40 sda_oe_n = b;
        #40 scl = 1'b1;
        #80 r = sda;
        scl = 1'b0;
    end
    endtask
    // Start, address, ack, byte, ack or nack, stop
    task xfer(input logic [7:0] a, input logic [7:0] d);
        int i;
        logic r;
    begin
        #3 sda_oe_n = 1'b0;
        #80 scl = 1'b0;
        for (i = 7; i >= 0; i--)
            bit_io(a[i], r);
        bit_io(1'b1, ack[1]);
        for (i = 7; i >= 0; i--)
            bit_io(a[0] | d[i], rd[i]);
        bit_io(1'b1, ack[0]);
        #40 sda_oe_n = 1'b0;
        #40 scl = 1'b1;
        #80 sda_oe_n = 1'b1;
        #80;
    end
    endtask
endmodule // lbc_host

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
// Serial and pin variants side by side
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic undervoltage_lockout = 1'b0;
    logic power_good_input = 1'b1;
    logic polarity_select = 1'b1;
    logic raise_magnitude_pin = 1'b0;
    logic lower_magnitude_pin = 1'b0;
    logic shutdown_n_pin = 1'b1;
    logic suspend_n_pin = 1'b1;
    logic [1:0] oper_cfg = 2'h3;
    logic [1:0] susp_cfg = 2'h0;
    logic [4:0] code = 5'h10;
    logic [11:0] exq [$];
    logic [11:0] e;
    logic [9:0] obs [4];
    int errors = 0;
    int compares = 0;
    int i;
    wire scl_in, h_oe_n, sda_oe_n, panel_switch_oe_n, running, p_pan, p_run;
    wire [4:0] dac_out, p_dac;
    wire sda_in = h_oe_n & sda_oe_n;
    lbc_host host (.sda(sda_in), .scl(scl_in), .sda_oe_n(h_oe_n));
    lbc_ctrl #(.SERIAL_MODE(1)) uut (.clk(clk), .sys_rst(sys_rst),
        .undervoltage_lockout(undervoltage_lockout), .power_good_input(power_good_input),
        .polarity_select(polarity_select), .raise_magnitude_pin(raise_magnitude_pin),
        .lower_magnitude_pin(lower_magnitude_pin), .shutdown_n_pin(shutdown_n_pin),
        .suspend_n_pin(suspend_n_pin), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
        .dac_out(dac_out), .panel_switch_oe_n(panel_switch_oe_n), .running(running));
    lbc_ctrl #(.SERIAL_MODE(0)) uut_pin (.clk(clk), .sys_rst(sys_rst),
        .undervoltage_lockout(undervoltage_lockout), .power_good_input(power_good_input),
        .polarity_select(polarity_select), .raise_magnitude_pin(raise_magnitude_pin),
        .lower_magnitude_pin(lower_magnitude_pin), .shutdown_n_pin(shutdown_n_pin),
        .suspend_n_pin(suspend_n_pin), .scl_in(1'b1), .sda_in(1'b1), .sda_oe_n(),
        .dac_out(p_dac), .panel_switch_oe_n(p_pan), .running(p_run));
    // Clock
    initial forever #5 clk = ~clk;
    // Probe settled outputs mid-cycle, then compare pending notes
    always @(negedge clk)
    begin
        obs[0] = {4'h0, running, dac_out};
        obs[1] = {4'h0, p_run, p_dac};
        obs[2] = {host.ack, host.rd};
        obs[3] = {8'h00, p_pan, panel_switch_oe_n};
        while (exq.size() > 0)
        begin
            e = exq.pop_front();
            chk(e[11:10], obs[e[11:10]], e[9:0]);
        end
    end
    task chk(input [1:0] s, input [9:0] seen, input [9:0] exp);
    begin
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected probe%0d expected %h seen %h", s, exp, seen);
        end
    end
    endtask
    task ex(input [1:0] s, input [9:0] v);
        exq.push_back({s, v});
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Raise and lower strobes at the link rate
    task strobe_pins(input int n, input logic u, input logic d);
        repeat (n)
        begin
            raise_magnitude_pin <= u;
            lower_magnitude_pin <= d;
            cyc(8);
            raise_magnitude_pin <= 1'b0;
            lower_magnitude_pin <= 1'b0;
            cyc(8);
        end
    endtask
    // Serial state and status readback
    task st;
        logic r;
    begin
        r = suspend_n_pin ? oper_cfg[1] : susp_cfg[1];
        ex(0, {4'h0, r, r ? code : 5'h00});
        host.xfer(8'h59, 8'h00);
        cyc(1);
        ex(2, {2'b01, power_good_input & r, 2'b00, code});
    end
    endtask
    // Byte write and its register effect
    task wr(input [7:0] a, input [7:0] d);
    begin
        host.xfer(a, d);
        if (a == 8'h58 && d[7])
            oper_cfg = d[6:5];
        else if (a == 8'h58)
            susp_cfg = d[6:5];
        if (a == 8'h58)
            code = d[4:0];
        cyc(4);
        ex(2, {a == 8'h58 ? 2'b00 : 2'b11, d});
        st;
    end
    endtask
    task stop_test;
    begin
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    // Watchdog
    initial
    begin
        #900000;
        errors++;
        stop_test;
    end
    // Main sequence
    initial
    begin
        void'($urandom(20));
        cyc(5);
        sys_rst <= 1'b0;
        cyc(6);
        ex(0, 10'h030);
        ex(3, 10'h000);
        strobe_pins(1, 1, 0);
        ex(1, 10'h02f);
        strobe_pins(15, 1, 0);
        ex(1, 10'h020);
        strobe_pins(1, 1, 0);
        ex(1, 10'h020);
        strobe_pins(1, 1, 1);
        ex(1, 10'h030);
        strobe_pins(15, 0, 1);
        ex(1, 10'h03f);
        strobe_pins(1, 0, 1);
        ex(1, 10'h03f);
        polarity_select <= 1'b0;
        strobe_pins(1, 0, 1);
        ex(1, 10'h03e);
        shutdown_n_pin <= 1'b0;
        strobe_pins(2, 0, 1);
        ex(1, 10'h000);
        ex(3, 10'h002);
        shutdown_n_pin <= 1'b1;
        cyc(6);
        ex(1, 10'h03e);
        power_good_input <= 1'b0;
        cyc(6);
        ex(3, 10'h003);
        power_good_input <= 1'b1;
        undervoltage_lockout <= 1'b1;
        cyc(8);
        undervoltage_lockout <= 1'b0;
        cyc(6);
        ex(1, 10'h030);
        wr(8'h5a, 8'h07);
        wr(8'h58, 8'h07);
        suspend_n_pin <= 1'b0;
        cyc(6);
        st;
        wr(8'h58, 8'h5b);
        ex(3, 10'h001);
        suspend_n_pin <= 1'b1;
        cyc(6);
        st;
        ex(3, 10'h000);
        wr(8'h58, 8'h85);
        for (i = 0; i < 5; i++)
            wr(8'h58, 8'($urandom));
        cyc(2);
        stop_test;
    end
endmodule // tb_top
